// [hw/sebsfe_device.sv]
`timescale 1ns/100ps
module sebsfe_device
#(
  parameter int PROG_CYCLES = sebsfe_pkg::PROG_CYCLES
)
(
  input  wire logic     clk,
  input  wire logic     reset_n,
  input  wire logic     chip_select_pin_zero,
  input  wire logic     chip_select_pin_one,
  input  wire logic     chip_select_pin_two,
  input  wire logic     write_protect,
  output logic          busy,
  output logic          standby,
  sebsfe_link_if.device link
);
  localparam int AW = sebsfe_pkg::ADDR_W;
  localparam int PW = sebsfe_pkg::PAGE_W;
  localparam int BW = sebsfe_pkg::BASE_W;
  logic [7:0]                     mem [0:sebsfe_pkg::MEM_BYTES-1];
  logic [7:0]                     page_buf [0:sebsfe_pkg::PAGE_BYTES-1];
  logic [sebsfe_pkg::PAGE_BYTES-1:0] page_mask;
  logic [BW-1:0]                  page_base;
  logic [AW-1:0]                  addr;
  logic                           start_tog;
  logic                           stop_tog;
  logic                           start_seen;
  logic                           start_done;
  logic [3:0]                     bit_cnt;
  logic [7:0]                     rx;
  logic [7:0]                     tx;
  logic                           ack_go;
  logic                           wr_pend;
  logic                           sda_oe;
  logic [2:0]                     cs_s1;
  logic [2:0]                     cs_s2;
  logic                           busy_l1;
  logic                           busy_l2;
  sebsfe_pkg::sebsfe_link_state_t lstate;
  logic [2:0]                     stop_s;
  logic [2:0]                     start_s;
  logic [1:0]                     wr_pend_s;
  logic [1:0]                     wp_s;
  logic [PW-1:0]                  idx;
  logic [31:0]                    prog_timer;
  sebsfe_pkg::sebsfe_prog_state_t pstate;
  wire logic [7:0]    rx_byte     = {rx[6:0], link.sda};
  wire logic          start_pend  = start_seen != start_done;
  wire logic          last_bit    = bit_cnt == sebsfe_pkg::BYTE_LAST_IDX;
  wire logic          ack_clk     = bit_cnt == sebsfe_pkg::ACK_BIT_IDX;
  wire logic          fix_ok      = rx_byte[7:sebsfe_pkg::CMD_FIX_LSB] == sebsfe_pkg::CMD_FIXED;
  wire logic          cs_ok       = rx_byte[3:sebsfe_pkg::CMD_CS_LSB] == cs_s2;
  wire logic          cmd_match   = fix_ok && cs_ok && !busy_l2;
  wire logic          cmd_read    = rx_byte[sebsfe_pkg::CMD_RW_BIT];
  wire logic [7:0]    rd_data     = mem[addr];
  wire logic [PW-1:0] addr_lo_nxt = addr[PW-1:0] + 1'b1;
  wire logic [AW-1:0] addr_nxt    = addr + 1'b1;
  wire logic [7:0]    tx_src      = bit_cnt == 4'h0 ? rd_data : tx;
  wire logic          stop_evt    = stop_s[2] ^ stop_s[1];
  wire logic          start_evt   = start_s[2] ^ start_s[1];
  wire logic          prog_go     = pstate == sebsfe_pkg::PS_IDLE && stop_evt && wr_pend_s[1] && !wp_s[1];
  wire logic          prog_done   = pstate == sebsfe_pkg::PS_WAIT && prog_timer == 32'(PROG_CYCLES - 1);
  wire logic          copy_last   = idx == PW'(sebsfe_pkg::PAGE_BYTES - 1);
  assign link.d_sda_o  = 1'b0;
  assign link.d_sda_oe = sda_oe;
  // bus conditions clock on sda itself; an sda edge counts only while scl is high
  always_ff @(negedge link.sda or negedge reset_n)
    if (!reset_n)
      start_tog <= 1'b0;
    else if (link.scl)
      start_tog <= ~start_tog;
  always_ff @(posedge link.sda or negedge reset_n)
    if (!reset_n)
      stop_tog <= 1'b0;
    else if (link.scl)
      stop_tog <= ~stop_tog;
  // straps and busy cross into the scl domain
  always_ff @(posedge link.scl or negedge reset_n)
    if (!reset_n)
    begin
      cs_s1   <= 3'h0;
      cs_s2   <= 3'h0;
      busy_l1 <= 1'b0;
      busy_l2 <= 1'b0;
    end
    else
    begin
      cs_s1   <= {chip_select_pin_two, chip_select_pin_one, chip_select_pin_zero};
      cs_s2   <= cs_s1;
      busy_l1 <= busy;
      busy_l2 <= busy_l1;
    end
  always_ff @(posedge link.scl or negedge reset_n)
    if (!reset_n)
    begin
      start_done <= 1'b0;
      rx         <= 8'h00;
      bit_cnt    <= 4'h0;
      ack_go     <= 1'b0;
      wr_pend    <= 1'b0;
      addr       <= '0;
      page_base  <= '0;
      page_mask  <= '0;
      lstate     <= sebsfe_pkg::LS_IDLE;
    end
    else if (start_pend)
    begin
      // first rise after start carries b7 of the command; a new start drops pending writes
      start_done <= start_seen;
      rx         <= {7'h00, link.sda};
      bit_cnt    <= 4'h1;
      ack_go     <= 1'b0;
      wr_pend    <= 1'b0;
      lstate     <= sebsfe_pkg::LS_CMD;
    end
    else if (ack_clk)
    begin
      bit_cnt <= 4'h0;
      ack_go  <= 1'b0;
      if (lstate == sebsfe_pkg::LS_RDATA && link.sda)
        lstate <= sebsfe_pkg::LS_IDLE;
    end
    else
    begin
      rx      <= rx_byte;
      bit_cnt <= bit_cnt + 4'h1;
      if (last_bit)
      begin
        unique case (lstate)
          sebsfe_pkg::LS_CMD:
          begin
            ack_go <= cmd_match;
            lstate <= !cmd_match ? sebsfe_pkg::LS_IDLE :
                      cmd_read ? sebsfe_pkg::LS_RDATA : sebsfe_pkg::LS_ADDR_HI;
            if (cmd_match && !cmd_read)
              page_mask <= '0;
          end
          sebsfe_pkg::LS_ADDR_HI:
          begin
            addr[AW-1:AW-sebsfe_pkg::ADDR_HI_W] <= rx_byte[sebsfe_pkg::ADDR_HI_W-1:0];
            ack_go <= 1'b1;
            lstate <= sebsfe_pkg::LS_ADDR_LO;
          end
          sebsfe_pkg::LS_ADDR_LO:
          begin
            addr[7:0] <= rx_byte;
            page_base <= {addr[AW-1:8], rx_byte[7:PW]};
            ack_go    <= 1'b1;
            lstate    <= sebsfe_pkg::LS_WDATA;
          end
          sebsfe_pkg::LS_WDATA:
          begin
            // only the low five bits advance: page writes wrap inside the page
            page_buf[addr[PW-1:0]]  <= rx_byte;
            page_mask[addr[PW-1:0]] <= 1'b1;
            addr[PW-1:0]            <= addr_lo_nxt;
            wr_pend                 <= 1'b1;
            ack_go                  <= 1'b1;
          end
          sebsfe_pkg::LS_RDATA:
            addr <= addr_nxt;
          default:
            lstate <= sebsfe_pkg::LS_IDLE;
        endcase
      end
    end
  // outgoing bits change only after scl falls, so they are stable while scl is high
  always_ff @(negedge link.scl or negedge reset_n)
    if (!reset_n)
    begin
      start_seen <= 1'b0;
      sda_oe     <= 1'b0;
      tx         <= 8'h00;
    end
    else
    begin
      start_seen <= start_tog;
      if (ack_clk)
        sda_oe <= ack_go;
      else if (lstate == sebsfe_pkg::LS_RDATA)
      begin
        sda_oe <= ~tx_src[7];
        tx     <= {tx_src[6:0], 1'b0};
      end
      else
        sda_oe <= 1'b0;
    end
  // scl is quiet after stop, so page buffer and mask are stable during the copy
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      stop_s    <= 3'h0;
      start_s   <= 3'h0;
      wr_pend_s <= 2'h0;
      wp_s      <= 2'h0;
    end
    else
    begin
      stop_s    <= {stop_s[1:0], stop_tog};
      start_s   <= {start_s[1:0], start_tog};
      wr_pend_s <= {wr_pend_s[0], wr_pend};
      wp_s      <= {wp_s[0], write_protect};
    end
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      pstate     <= sebsfe_pkg::PS_IDLE;
      idx        <= '0;
      prog_timer <= 32'h0;
      busy       <= 1'b0;
    end
    else
    begin
      unique case (pstate)
        sebsfe_pkg::PS_IDLE:
          if (prog_go)
          begin
            pstate <= sebsfe_pkg::PS_COPY;
            idx    <= '0;
            busy   <= 1'b1;
          end
        sebsfe_pkg::PS_COPY:
        begin
          idx <= idx + 1'b1;
          if (copy_last)
          begin
            pstate     <= sebsfe_pkg::PS_WAIT;
            prog_timer <= 32'h0;
          end
        end
        sebsfe_pkg::PS_WAIT:
        begin
          prog_timer <= prog_timer + 32'h1;
          if (prog_done)
          begin
            pstate <= sebsfe_pkg::PS_IDLE;
            busy   <= 1'b0;
          end
        end
        default:
          pstate <= sebsfe_pkg::PS_IDLE;
      endcase
    end
  // unaddressed bytes of the page keep their contents
  always_ff @(posedge clk)
    if (pstate == sebsfe_pkg::PS_COPY && page_mask[idx])
      mem[{page_base, idx}] <= page_buf[idx];
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      standby <= 1'b1;
    else if (start_evt)
      standby <= 1'b0;
    else if ((stop_evt && !prog_go) || prog_done)
      standby <= 1'b1;
endmodule

// [hw/sebsfe_master.sv]
`timescale 1ns/100ps
module sebsfe_master
#(
  parameter int QTR_CYCLES = sebsfe_pkg::QTR_CYCLES
)
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              op_valid,
  input  wire sebsfe_pkg::sebsfe_op_t op_code,
  input  wire logic [7:0]        op_byte,
  input  wire logic              op_ack,
  output logic                   op_ready,
  output logic                   done,
  output logic [7:0]             rx_byte,
  output logic                   rx_ack,
  sebsfe_link_if.master          link
);
  sebsfe_pkg::sebsfe_master_state_t mstate;
  logic [1:0]  phase;
  logic [15:0] qcnt;
  logic [3:0]  bit_idx;
  logic [7:0]  shift;
  logic        is_read;
  logic        send_ack;
  logic        scl;
  logic        sda_oe;
  logic [1:0]  sda_s;

  wire logic tick    = qcnt == 16'(QTR_CYCLES - 1);
  wire logic ack_bit = bit_idx == sebsfe_pkg::ACK_BIT_IDX;

  assign link.scl      = scl;
  assign link.m_sda_o  = 1'b0;
  assign link.m_sda_oe = sda_oe;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      sda_s <= 2'h3;
    else
      sda_s <= {sda_s[0], link.sda};

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      qcnt <= 16'h0;
    else if (tick || mstate == sebsfe_pkg::MS_IDLE)
      qcnt <= 16'h0;
    else
      qcnt <= qcnt + 16'h1;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      mstate   <= sebsfe_pkg::MS_IDLE;
      phase    <= 2'h0;
      bit_idx  <= 4'h0;
      shift    <= 8'h00;
      is_read  <= 1'b0;
      send_ack <= 1'b0;
      scl      <= 1'b1;
      sda_oe   <= 1'b0;
      op_ready <= 1'b1;
      done     <= 1'b0;
      rx_byte  <= 8'h00;
      rx_ack   <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      unique case (mstate)
        sebsfe_pkg::MS_IDLE:
          if (op_valid)
          begin
            op_ready <= 1'b0;
            shift    <= op_byte;
            is_read  <= op_code == sebsfe_pkg::OP_READ;
            send_ack <= op_ack;
            phase    <= 2'h0;
            bit_idx  <= 4'h0;
            unique case (op_code)
              sebsfe_pkg::OP_START: mstate <= sebsfe_pkg::MS_START;
              sebsfe_pkg::OP_STOP:  mstate <= sebsfe_pkg::MS_STOP;
              sebsfe_pkg::OP_WRITE,
              sebsfe_pkg::OP_READ:  mstate <= sebsfe_pkg::MS_BIT;
            endcase
          end
        sebsfe_pkg::MS_START:
          if (tick)
          begin
            phase <= phase + 2'h1;
            unique case (phase)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl <= 1'b1;
              2'h2: sda_oe <= 1'b1;
              2'h3:
              begin
                scl    <= 1'b0;
                mstate <= sebsfe_pkg::MS_BIT;
              end
            endcase
          end
        sebsfe_pkg::MS_BIT:
          if (tick)
          begin
            phase <= phase + 2'h1;
            unique case (phase)
              2'h0: sda_oe <= ack_bit ? (is_read && send_ack) : (!is_read && !shift[7]);
              2'h1: scl <= 1'b1;
              2'h2: scl <= 1'b1;
              2'h3:
              begin
                scl     <= 1'b0;
                bit_idx <= bit_idx + 4'h1;
                if (!ack_bit)
                  shift <= {shift[6:0], sda_s[1]};
                else
                begin
                  // own ack is held past the scl fall; a next bit or start lets it go while scl is low, a stop keeps sda low
                  rx_ack   <= !sda_s[1];
                  rx_byte  <= shift;
                  done     <= 1'b1;
                  op_ready <= 1'b1;
                  mstate   <= sebsfe_pkg::MS_IDLE;
                end
              end
            endcase
          end
        sebsfe_pkg::MS_STOP:
          if (tick)
          begin
            phase <= phase + 2'h1;
            unique case (phase)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl <= 1'b1;
              2'h2: sda_oe <= 1'b0;
              2'h3:
              begin
                done     <= 1'b1;
                op_ready <= 1'b1;
                mstate   <= sebsfe_pkg::MS_IDLE;
              end
            endcase
          end
      endcase
    end
endmodule

// [inc/sebsfe_link_if.sv]
`timescale 1ns/100ps
interface sebsfe_link_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic sda;

  // wired and with pull-up: any enabled low driver wins
  assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

  modport master
  (
    output scl,
    output m_sda_o,
    output m_sda_oe,
    input  sda
  );

  modport device
  (
    input  scl,
    output d_sda_o,
    output d_sda_oe,
    input  sda
  );
endinterface

// [inc/sebsfe_pkg.sv]
package sebsfe_pkg;
  localparam int CLK_HZ       = 50_000_000;
  localparam int SCL_HZ       = 400_000;
  // quarter bit time is a least time, so it rounds up
  localparam int QTR_CYCLES   = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam int PROG_TIME_US = 8000;
  // longest programming time rounds down
  localparam int PROG_CYCLES  = PROG_TIME_US * (CLK_HZ / 1_000_000);

  localparam int MEM_BYTES  = 4096;
  localparam int PAGE_BYTES = 32;
  localparam int PAGES      = 128;
  localparam int ADDR_W     = 12;
  localparam int PAGE_W     = 5;
  localparam int BASE_W     = ADDR_W - PAGE_W;

  localparam logic [3:0] CMD_FIXED     = 4'ha;
  localparam int         CMD_RW_BIT    = 0;
  localparam int         CMD_CS_LSB    = 1;
  localparam int         CMD_FIX_LSB   = 4;
  localparam int         ADDR_HI_W     = 4;
  localparam logic [3:0] BYTE_LAST_IDX = 4'h7;
  localparam logic [3:0] ACK_BIT_IDX   = 4'h8;

  typedef enum logic [2:0]
  {
    LS_IDLE    = 3'h0,
    LS_CMD     = 3'h1,
    LS_ADDR_HI = 3'h2,
    LS_ADDR_LO = 3'h3,
    LS_WDATA   = 3'h4,
    LS_RDATA   = 3'h5
  } sebsfe_link_state_t;

  typedef enum logic [1:0] {PS_IDLE = 2'h0, PS_COPY = 2'h1, PS_WAIT = 2'h2} sebsfe_prog_state_t;

  typedef enum logic [1:0] {OP_START = 2'h0, OP_WRITE = 2'h1, OP_READ = 2'h2, OP_STOP = 2'h3} sebsfe_op_t;

  typedef enum logic [1:0] {MS_IDLE = 2'h0, MS_START = 2'h1, MS_BIT = 2'h2, MS_STOP = 2'h3} sebsfe_master_state_t;
endpackage

// [tb/sebsfe_link_monitor.sv]
`timescale 1ns/100ps
module sebsfe_link_monitor
(
  input logic clk,
  input logic reset_n,
  input logic scl,
  input logic m_sda_o,
  input logic m_sda_oe,
  input logic d_sda_o,
  input logic d_sda_oe,
  input logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [7:0] cmd;
  logic       cmd_acked;
  logic       rd_nacked;
  // scl is far slower than clk, so edges are seen on clk
  wire        scl_rise  = scl && !scl_q;
  wire        start_det = scl && scl_q && sda_q && !sda;
  wire        ninth     = bit_cnt == sebsfe_pkg::ACK_BIT_IDX;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
    end

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      bit_cnt <= 4'h0;
    else if (start_det)
      bit_cnt <= 4'h0;
    else if (scl_rise)
      bit_cnt <= ninth ? 4'h0 : bit_cnt + 4'h1;

  // saturates: only first byte versus later bytes matters
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      byte_cnt <= 2'h0;
    else if (start_det)
      byte_cnt <= 2'h0;
    else if (scl_rise && ninth && byte_cnt != 2'h2)
      byte_cnt <= byte_cnt + 2'h1;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      cmd <= 8'h00;
    else if (scl_rise && byte_cnt == 2'h0 && !ninth)
      cmd <= {cmd[6:0], sda};

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      cmd_acked <= 1'b0;
      rd_nacked <= 1'b0;
    end
    else if (start_det)
      rd_nacked <= 1'b0;
    else if (scl_rise && ninth && byte_cnt == 2'h0)
      cmd_acked <= d_sda_oe;
    else if (scl_rise && ninth && cmd[0])
      rd_nacked <= sda;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_ninth_rise;
    scl_rise && ninth;
  endsequence

  sequence s_high_hold;
    $stable(d_sda_oe) [*3];
  endsequence

  a_drive_open_drain: assert property ((d_sda_oe || m_sda_oe) |-> !d_sda_o && !m_sda_o)
    else $error("sda driven high");
  a_change_on_fall: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device sda changed with scl high");
  a_stable_scl_high: assert property (scl_rise |=> s_high_hold)
    else $error("device sda moved during scl high");
  a_cmd_pattern_nack: assert property (scl_rise && (byte_cnt != 2'h0 || ninth)
    && cmd[7:4] != sebsfe_pkg::CMD_FIXED |-> !d_sda_oe)
    else $error("sda driven after foreign command");
  a_write_byte_ack: assert property (s_ninth_rise ##0 (byte_cnt != 2'h0 && !cmd[0] && cmd_acked) |-> d_sda_oe)
    else $error("written byte not acknowledged");
  a_read_ack_release: assert property (s_ninth_rise ##0 (byte_cnt != 2'h0 && cmd[0]) |-> !d_sda_oe)
    else $error("device held sda in master ack clock");
  a_ack_bit_window: assert property (scl_rise && !ninth && !(cmd[0] && cmd_acked && byte_cnt != 2'h0)
    |-> !d_sda_oe)
    else $error("device drove sda outside ack clock");
  a_nack_ends_read: assert property (scl_rise && rd_nacked |-> !d_sda_oe)
    else $error("device drove sda after master nack");
endmodule

// [tb/tb_serial_eeprom_bus_slave_front_end.sv]
`timescale 1ns/100ps
module tb_serial_eeprom_bus_slave_front_end;
  typedef struct packed {logic care; logic [7:0] data; logic ack;} sebsfe_note_t;
  logic                   clk;
  logic                   reset_n;
  logic [2:0]             cs;
  logic                   wp;
  logic                   op_valid;
  sebsfe_pkg::sebsfe_op_t op_code;
  logic [7:0]             op_byte;
  logic                   op_ack;
  logic                   op_ready;
  logic                   done;
  logic [7:0]             rx_byte;
  logic                   rx_ack;
  logic                   busy;
  logic                   standby;
  logic [7:0]             lfsr;
  logic [7:0]             cmd_w;
  logic [7:0]             d0;
  logic [7:0]             d1;
  logic [7:0]             d2;
  sebsfe_note_t           note;
  sebsfe_note_t           notes[$];
  int                     miscompares;
  int                     num_checks;
  int                     cycles;

  sebsfe_link_if link ();

  sebsfe_master #(.QTR_CYCLES(2)) i_sebsfe_master
  (
    .clk(clk), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code), .op_byte(op_byte),
    .op_ack(op_ack), .op_ready(op_ready), .done(done), .rx_byte(rx_byte), .rx_ack(rx_ack), .link(link.master)
  );

  // short programming time keeps the run brief but still outlasts one poll byte
  sebsfe_device #(.PROG_CYCLES(600)) i_sebsfe_device
  (
    .clk(clk), .reset_n(reset_n), .chip_select_pin_zero(cs[0]), .chip_select_pin_one(cs[1]),
    .chip_select_pin_two(cs[2]), .write_protect(wp), .busy(busy), .standby(standby), .link(link.device)
  );

  sebsfe_link_monitor i_sebsfe_link_monitor
  (
    .clk(clk), .reset_n(reset_n), .scl(link.scl), .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
    .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe), .sda(link.sda)
  );

  function automatic logic [7:0] next_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // request held from one falling edge until op_ready was high at a rising edge
  task automatic op(input sebsfe_pkg::sebsfe_op_t c, input logic [7:0] b, input logic a, input sebsfe_note_t n);
    int k;
    k = 0;
    notes.push_back(n);
    @(negedge clk);
    op_valid = 1'b1;
    op_code = c;
    op_byte = b;
    op_ack = a;
    while (op_ready !== 1'b1 && k < 100)
    begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    op_valid = 1'b0;
    k = 0;
    while (op_ready !== 1'b1 && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    if (op_ready !== 1'b1)
    begin
      miscompares++;
      $display("Error at %0t: operation never finished", $time);
    end
  endtask

  task automatic st(input logic [7:0] b, input logic ea);
    op(sebsfe_pkg::OP_START, b, 1'b0, {1'b1, b, ea});
  endtask

  task automatic wr(input logic [7:0] b, input logic ea);
    op(sebsfe_pkg::OP_WRITE, b, 1'b0, {1'b1, b, ea});
  endtask

  task automatic rd(input logic [7:0] ed, input logic a);
    op(sebsfe_pkg::OP_READ, 8'h00, a, {1'b1, ed, a});
  endtask

  task automatic sp();
    op(sebsfe_pkg::OP_STOP, 8'h00, 1'b0, 10'h000);
  endtask

  task automatic seek(input logic [7:0] lo);
    st(cmd_w, 1'b1);
    wr(8'h00, 1'b1);
    wr(lo, 1'b1);
  endtask

  task automatic wbusy(input logic v, input int lim);
    int k;
    k = 0;
    while (busy !== v && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    chk({8'h00, busy}, {8'h00, v});
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
    if (done === 1'b1)
    begin
      if (notes.size() == 0)
        chk(9'h000, 9'h1ff);
      else
      begin
        note = notes.pop_front();
        if (note.care)
          chk({rx_byte, rx_ack}, {note.data, note.ack});
      end
    end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  initial
  begin
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    lfsr = 8'h3f;
    cs = lfsr[2:0];
    wp = 1'b0;
    op_valid = 1'b0;
    op_code = sebsfe_pkg::OP_STOP;
    op_byte = 8'h00;
    op_ack = 1'b0;
    reset_n = 1'b0;
    lfsr = next_rand(lfsr);
    d0 = lfsr;
    lfsr = next_rand(lfsr);
    d1 = lfsr;
    lfsr = next_rand(lfsr);
    d2 = lfsr;
    cmd_w = {sebsfe_pkg::CMD_FIXED, cs, 1'b0};
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    seek(8'h1e);
    wr(d0, 1'b1);
    wr(d1, 1'b1);
    wr(d2, 1'b1);
    sp();
    wbusy(1'b1, 20);
    st(cmd_w, 1'b0);
    sp();
    wbusy(1'b0, 800);
    chk({8'h00, standby}, 9'h001);
    $display("test page_write done");
    seek(8'h1e);
    st(cmd_w | 8'h01, 1'b1);
    chk({8'h00, standby}, 9'h000);
    rd(d0, 1'b1);
    rd(d1, 1'b0);
    sp();
    seek(8'h00);
    st(cmd_w | 8'h01, 1'b1);
    rd(d2, 1'b0);
    sp();
    $display("test read_back done");
    for (int i = 0; i < 3; i++)
    begin
      st({sebsfe_pkg::CMD_FIXED, cs ^ (3'h1 << i), 1'b1}, 1'b0);
      sp();
    end
    st({4'h5, cs, 1'b0}, 1'b0);
    sp();
    $display("test refusals done");
    wp = 1'b1;
    seek(8'h00);
    wr(~d2, 1'b1);
    sp();
    repeat (20) @(negedge clk);
    wbusy(1'b0, 800);
    wp = 1'b0;
    seek(8'h00);
    st(cmd_w | 8'h01, 1'b1);
    rd(d2, 1'b0);
    sp();
    $display("test write_protect done");
    finish_test();
  end
endmodule
